// ---- rtl/dsc_pkg.sv ----
// Shared constants and types of the drum storage controller
package dsc_pkg;

  // Device address answered on the processor I/O bus
  localparam logic [7:0] DEV_ADDR_DEF = 8'h86;

  // Direction command byte values, low two bits
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;

  // Status bit positions in the data byte; status bit 0 is the MSB
  localparam int ST_XFER_ERR = 7;
  localparam int ST_PARITY   = 6;
  localparam int ST_ZERO     = 5;
  localparam int ST_PROTECT  = 4;
  localparam int ST_BUSY     = 3;
  localparam int ST_EXAMINE  = 2;
  localparam int ST_EOM      = 1;
  localparam int ST_UNAVAIL  = 0;

  // Reset values
  localparam logic [7:0]  DATA_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  // Sector layout: four groups of 32 data bytes, each followed by a parity byte
  localparam logic [4:0] GPOS_LAST = 5'h1F;
  localparam logic [1:0] GRP_LAST  = 2'h3;

  // Highest valid sector address per drum capacity
  localparam logic [15:0] MAX_128K  = 16'h03FF;
  localparam logic [15:0] MAX_256K  = 16'h07FF;
  localparam logic [15:0] MAX_512K  = 16'h0FFF;
  localparam logic [15:0] MAX_1024K = 16'h1FFF;
  localparam logic [15:0] MAX_2048K = 16'h3FFF;
  localparam logic [2:0]  CAP_128K  = 3'h0;
  localparam logic [2:0]  CAP_256K  = 3'h1;
  localparam logic [2:0]  CAP_512K  = 3'h2;
  localparam logic [2:0]  CAP_1024K = 3'h3;

  // Protect group: 16 tracks of 32 sectors, so sector address bits 13:9
  localparam int PROT_LSB = 9;
  localparam int PROT_MSB = 13;

  // Data FIFO shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  // One request cycle on the processor I/O bus
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       sense;
    logic       out_cmd;
    logic       wr_data;
  } dsc_bus_req_t;

  // Drum byte slot sequencer
  typedef enum logic [2:0] {
    DSC_IDLE   = 3'b001,
    DSC_DATA   = 3'b010,
    DSC_PARITY = 3'b100
  } dsc_state_t;

endpackage

// ---- rtl/dsc_fifo.sv ----
// Byte FIFO with valid and ready on both sides
`timescale 1ns/100ps
module dsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic             flush_i,
  // Filling side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Draining side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;
  assign out_data_o = mem_r[rd_ptr_r];

  // Occupancy; flags come from the next count so they stay registered
  always_comb
  begin
    count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush_i)
    begin
      count_nxt = '0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_r     <= '0;
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      count_r     <= count_nxt;
      wr_ptr_r    <= flush_i ? '0 : wr_ptr_r + AW'(push);
      rd_ptr_r    <= flush_i ? '0 : rd_ptr_r + AW'(pop);
      in_ready_o  <= count_nxt != (AW+1)'(DEPTH);
      out_valid_o <= count_nxt != '0;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end
endmodule

// ---- rtl/dsc_parity.sv ----
// Running parity character over one 32-byte group
`timescale 1ns/100ps
module dsc_parity (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Control and data
  input  wire logic       clear_i,
  input  wire logic       load_i,
  input  wire logic [7:0] byte_i,
  output logic      [7:0] parity_o
);
  // Column XOR of every byte since the last clear
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      parity_o <= dsc_pkg::DATA_RST;
    end
    else if (clear_i)
    begin
      parity_o <= dsc_pkg::DATA_RST;
    end
    else if (load_i)
    begin
      parity_o <= parity_o ^ byte_i;
    end
  end
endmodule

// ---- rtl/dsc_ctrl.sv ----
// Drum storage controller: bus registers, byte sequencer, status
// What this block does
// (RQ1) Initialization selects read direction and clears all status flags except busy, which it sets.
// (RQ2) Answers the processor bus at its own address only while channel idle.
// (RQ3) Sense requests return the status byte; command and data write requests answer with zero.
// (RQ4) Transfer error sets when a byte is lost in either direction.
// (RQ5) Transfer error sets when a command picks both or neither direction.
// (RQ6) Status bit 1 reports a drum read parity error.
// (RQ7) Status bit 3 reports a write into a protected region.
// (RQ8) Busy bit low only when a byte can move with the channel.
// (RQ9) Examine is the OR of the three error flags and ends transfers.
// (RQ10) End of medium sets past the top address and ends transfers.
// (RQ11) Device unavailable on wrong speed or heads off; ends transfers.
// (RQ12) Heads engage only after minimum speed; unavailable until then.
// (RQ13) Software sends commands only while the channel is idle.
// (RQ14) Command 0x01 selects write direction, core to drum.
// (RQ15) Command 0x02 selects read direction, drum to core.
// (RQ16) Start address loads as two data writes, high byte first.
// (RQ17) Top start address follows drum capacity, 0x03FF up to 0x3FFF.
// (RQ18) Device address defaults to 0x86 and is a build option.
// (RQ19) Software loads drum and core addresses before the channel starts.
// (RQ20) Sectors hold 128 data bytes plus parity, 32 per track.
// (RQ21) Parity byte written after each 32 bytes, checked on read.
// (RQ22) Write into a protected 16-track group sets flags, ends transfer.
// (RQ23) Status bit 2 always reads zero.
// (RQ24) Sector address advances by one per 128-byte sector.
`timescale 1ns/100ps
module dsc_ctrl #(
  parameter logic [7:0] DEV_ADDR = dsc_pkg::DEV_ADDR_DEF
) (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  reset_n_i,
  // Processor I/O bus
  input  wire dsc_pkg::dsc_bus_req_t bus_req_i,
  input  wire logic                  chan_idle_i,
  output logic                       bus_resp_o,
  output logic                [7:0]  bus_data_o,
  // Selector channel byte stream
  input  wire logic                  chan_wr_valid_i,
  input  wire logic           [7:0]  chan_wr_data_i,
  output logic                       chan_wr_ready_o,
  output logic                       chan_rd_valid_o,
  output logic                [7:0]  chan_rd_data_o,
  input  wire logic                  chan_rd_ready_i,
  output logic                       chan_busy_o,
  output logic                       chan_term_o,
  // Drum byte slots
  input  wire logic                  drum_tick_i,
  input  wire logic           [7:0]  drum_rd_data_i,
  output logic                [7:0]  drum_wr_data_o,
  output logic                       drum_wr_en_o,
  output logic               [15:0]  drum_sector_o,
  // Drum condition and straps
  input  wire logic                  drum_speed_ok_i,
  input  wire logic                  drum_heads_ok_i,
  output logic                       drum_heads_engage_o,
  input  wire logic           [2:0]  cap_sel_i,
  input  wire logic          [31:0]  protect_i
);
  dsc_pkg::dsc_state_t state_r;
  logic [4:0]  gpos_r;
  logic [1:0]  grp_r;
  logic        addr_hi_done_r;
  logic        wr_mode_r;
  logic        transfer_error_flag_r;
  logic        pty_r;
  logic        wpv_r;
  logic        eom_r;
  logic        du_r;
  logic        busy_r;
  logic [15:0] max_lim;
  logic        hit;
  logic        cmd_hit;
  logic        cmd_bad;
  logic        load_lo;
  logic        examine;
  logic        stop_w;
  logic        data_tick;
  logic        par_tick;
  logic        sect_end;
  logic        protected_w;
  logic        lost_w;
  logic        par_bad;
  logic        fifo_in_valid;
  logic [7:0]  fifo_in_data;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_out_ready;
  logic [7:0]  parity;
  logic [7:0]  status_w;

  // Bus decode; a busy channel hides the controller entirely
  assign hit     = chan_idle_i & (bus_req_i.addr == DEV_ADDR); // see RQ2, see RQ18
  assign cmd_hit = hit & bus_req_i.out_cmd;
  assign cmd_bad = (bus_req_i.data[1:0] != dsc_pkg::CMD_WRITE)
                 & (bus_req_i.data[1:0] != dsc_pkg::CMD_READ);
  assign load_lo = hit & bus_req_i.wr_data & addr_hi_done_r;

  // Capacity limit; unknown codes take the largest drum
  always_comb
  begin
    case (cap_sel_i)
      dsc_pkg::CAP_128K:  max_lim = dsc_pkg::MAX_128K;  // see RQ17
      dsc_pkg::CAP_256K:  max_lim = dsc_pkg::MAX_256K;
      dsc_pkg::CAP_512K:  max_lim = dsc_pkg::MAX_512K;
      dsc_pkg::CAP_1024K: max_lim = dsc_pkg::MAX_1024K;
      default:            max_lim = dsc_pkg::MAX_2048K;
    endcase
  end

  // Terminating conditions
  assign examine = transfer_error_flag_r | pty_r | wpv_r; // see RQ9
  assign stop_w  = examine | eom_r | du_r; // see RQ10, see RQ11

  // Byte slot qualifiers
  assign data_tick   = drum_tick_i & (state_r == dsc_pkg::DSC_DATA) & ~stop_w;
  assign par_tick    = drum_tick_i & (state_r == dsc_pkg::DSC_PARITY) & ~stop_w;
  assign sect_end    = par_tick & (grp_r == dsc_pkg::GRP_LAST);
  assign protected_w = wr_mode_r & protect_i[drum_sector_o[dsc_pkg::PROT_MSB:dsc_pkg::PROT_LSB]];
  // A slot with nothing to give or nowhere to put is a lost byte
  assign lost_w  = data_tick & ~protected_w
                 & (wr_mode_r ? ~fifo_out_valid : ~fifo_in_ready); // see RQ4
  assign par_bad = par_tick & ~wr_mode_r & (drum_rd_data_i != parity); // see RQ21

  // FIFO steering by direction
  assign fifo_in_valid  = wr_mode_r ? chan_wr_valid_i : data_tick;
  assign fifo_in_data   = wr_mode_r ? chan_wr_data_i : drum_rd_data_i;
  assign fifo_out_ready = wr_mode_r ? (data_tick & ~protected_w) : chan_rd_ready_i;
  assign chan_wr_ready_o = fifo_in_ready;
  assign chan_rd_valid_o = fifo_out_valid;
  assign chan_rd_data_o  = fifo_out_data;

  dsc_fifo #(
    .WIDTH (dsc_pkg::FIFO_WIDTH),
    .DEPTH (dsc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .flush_i     (state_r == dsc_pkg::DSC_IDLE),
    .in_valid_i  (fifo_in_valid),
    .in_data_i   (fifo_in_data),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (fifo_out_ready)
  );

  // Parity accumulates data bytes in both directions
  dsc_parity u_parity (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .clear_i   (par_tick | (state_r == dsc_pkg::DSC_IDLE)),
    .load_i    (data_tick & ~lost_w & ~protected_w),
    .byte_i    (wr_mode_r ? fifo_out_data : drum_rd_data_i),
    .parity_o  (parity)
  );

  // Slot sequencer; the first tick after start is taken as a sector start
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= dsc_pkg::DSC_IDLE;
      gpos_r  <= '0;
      grp_r   <= '0;
    end
    else if (chan_idle_i | stop_w)
    begin
      state_r <= dsc_pkg::DSC_IDLE; // see RQ9, see RQ10, see RQ11
      gpos_r  <= '0;
      grp_r   <= '0;
    end
    else
    begin
      case (state_r)
        dsc_pkg::DSC_IDLE:
          state_r <= dsc_pkg::DSC_DATA;
        dsc_pkg::DSC_DATA:
          if (data_tick)
          begin
            gpos_r <= gpos_r + 5'h01;
            if (gpos_r == dsc_pkg::GPOS_LAST)
            begin
              state_r <= dsc_pkg::DSC_PARITY; // see RQ20
            end
          end
        dsc_pkg::DSC_PARITY:
          if (par_tick)
          begin
            grp_r   <= grp_r + 2'h1;
            state_r <= dsc_pkg::DSC_DATA;
          end
        default:
          state_r <= dsc_pkg::DSC_IDLE;
      endcase
    end
  end

  // Drum write path: data from FIFO, parity after each group
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      drum_wr_en_o   <= 1'b0;
      drum_wr_data_o <= dsc_pkg::DATA_RST;
    end
    else
    begin
      drum_wr_en_o <= 1'b0;
      if (wr_mode_r & data_tick & ~protected_w & fifo_out_valid)
      begin
        drum_wr_en_o   <= 1'b1;
        drum_wr_data_o <= fifo_out_data;
      end
      else if (wr_mode_r & par_tick)
      begin
        drum_wr_en_o   <= 1'b1; // see RQ21
        drum_wr_data_o <= parity;
      end
    end
  end

  // Start address load and per-sector advance
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      drum_sector_o  <= dsc_pkg::ADDR_RST;
      addr_hi_done_r <= 1'b0;
    end
    else
    begin
      if (cmd_hit)
      begin
        addr_hi_done_r <= 1'b0; // Command realigns the byte pairing
      end
      else if (hit & bus_req_i.wr_data)
      begin
        addr_hi_done_r <= ~addr_hi_done_r; // see RQ16
        if (addr_hi_done_r)
        begin
          drum_sector_o[7:0] <= bus_req_i.data;
        end
        else
        begin
          drum_sector_o[15:8] <= bus_req_i.data;
        end
      end
      else if (sect_end)
      begin
        drum_sector_o <= drum_sector_o + 16'h0001; // see RQ24
      end
    end
  end

  // Direction; reset leaves read selected
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_mode_r <= 1'b0; // see RQ1
    end
    else if (cmd_hit & (bus_req_i.data[1:0] == dsc_pkg::CMD_WRITE))
    begin
      wr_mode_r <= 1'b1; // see RQ14
    end
    else if (cmd_hit & (bus_req_i.data[1:0] == dsc_pkg::CMD_READ))
    begin
      wr_mode_r <= 1'b0; // see RQ15
    end
  end

  // Sticky error flags; a good command clears them, but a set wins
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      transfer_error_flag_r <= 1'b0; // see RQ1
      pty_r  <= 1'b0;
      wpv_r  <= 1'b0;
      eom_r  <= 1'b0;
    end
    else
    begin
      if (cmd_hit & ~cmd_bad)
      begin
        transfer_error_flag_r <= 1'b0;
        pty_r  <= 1'b0;
        wpv_r  <= 1'b0;
        eom_r  <= 1'b0;
      end
      if (lost_w | (cmd_hit & cmd_bad))
      begin
        transfer_error_flag_r <= 1'b1; // see RQ4, see RQ5
      end
      if (par_bad)
      begin
        pty_r <= 1'b1; // see RQ6
      end
      if (data_tick & protected_w)
      begin
        wpv_r <= 1'b1; // see RQ7, see RQ22
      end
      if ((load_lo & ({drum_sector_o[15:8], bus_req_i.data} > max_lim))
          | (sect_end & (drum_sector_o >= max_lim)))
      begin
        eom_r <= 1'b1; // see RQ10
      end
    end
  end

  // Heads follow speed; unavailable tracks both, a cycle later
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      drum_heads_engage_o <= 1'b0;
      du_r                <= 1'b0; // see RQ1
    end
    else
    begin
      drum_heads_engage_o <= drum_speed_ok_i; // see RQ12
      du_r <= ~drum_speed_ok_i | ~drum_heads_ok_i | ~drum_heads_engage_o; // see RQ11
    end
  end

  // Busy: low only while a byte can move with the channel
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy_r      <= 1'b1;
      chan_term_o <= 1'b0;
    end
    else
    begin
      busy_r <= (state_r == dsc_pkg::DSC_IDLE) | stop_w
              | (wr_mode_r ? ~fifo_in_ready : ~fifo_out_valid); // see RQ8
      chan_term_o <= ~chan_idle_i & stop_w;
    end
  end
  assign chan_busy_o = busy_r;

  // Status byte as returned on the bus
  always_comb
  begin
    status_w = dsc_pkg::DATA_RST;
    status_w[dsc_pkg::ST_XFER_ERR] = transfer_error_flag_r;
    status_w[dsc_pkg::ST_PARITY]   = pty_r;
    status_w[dsc_pkg::ST_PROTECT]  = wpv_r;
    status_w[dsc_pkg::ST_BUSY]     = busy_r;
    status_w[dsc_pkg::ST_EXAMINE]  = examine;
    status_w[dsc_pkg::ST_EOM]      = eom_r;
    status_w[dsc_pkg::ST_UNAVAIL]  = du_r;
    status_w[dsc_pkg::ST_ZERO]     = 1'b0; // see RQ23
  end

  // Bus answer one cycle after an addressed request
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      bus_resp_o <= 1'b0;
      bus_data_o <= dsc_pkg::DATA_RST;
    end
    else
    begin
      bus_resp_o <= hit & (bus_req_i.sense | bus_req_i.out_cmd | bus_req_i.wr_data);
      bus_data_o <= (hit & bus_req_i.sense) ? status_w : dsc_pkg::DATA_RST; // see RQ3
    end
  end

  // Checks
  AST_RESET_READ: assert property (@(posedge clock_i) // see RQ1
    $rose(reset_n_i) |-> !wr_mode_r && !transfer_error_flag_r && !pty_r && !wpv_r && !eom_r)
    else $error("controller not in read mode with clear flags after reset");
  AST_SILENT_BUSY: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ2
    !chan_idle_i |=> !bus_resp_o)
    else $error("bus answer while channel busy");
  AST_SENSE_DATA: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ3
    hit && bus_req_i.sense |=> bus_resp_o && bus_data_o == $past(status_w))
    else $error("sense did not return status");
  AST_LOST_BYTE: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ4
    lost_w |=> transfer_error_flag_r ##1 state_r == dsc_pkg::DSC_IDLE)
    else $error("lost byte not flagged or not stopped");
  AST_BAD_CMD: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ5
    cmd_hit && cmd_bad |=> transfer_error_flag_r && wr_mode_r == $past(wr_mode_r))
    else $error("bad direction command not flagged");
  AST_PARITY: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ21
    par_bad |=> pty_r && bus_data_o[dsc_pkg::ST_ZERO] == 1'b0)
    else $error("parity mismatch not flagged");
  AST_STOP: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ9
    examine || eom_r || du_r |=> state_r == dsc_pkg::DSC_IDLE && busy_r)
    else $error("transfer continued after terminating status");
  AST_WRITE_CMD: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ14
    cmd_hit && bus_req_i.data[1:0] == dsc_pkg::CMD_WRITE |=> wr_mode_r && !transfer_error_flag_r)
    else $error("write command did not select write");
  AST_HEADS: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ12
    !drum_speed_ok_i |=> !drum_heads_engage_o && du_r)
    else $error("heads engaged below speed");
  AST_SECT_ADV: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ24
    sect_end |=> drum_sector_o == $past(drum_sector_o) + 16'h0001)
    else $error("sector address did not advance");
  AST_PROTECT: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ22
    data_tick && protected_w |=> wpv_r && !drum_wr_en_o)
    else $error("protected write not refused");
  AST_ADDR_EOM: assert property (@(posedge clock_i) disable iff (!reset_n_i) // see RQ10
    load_lo && {drum_sector_o[15:8], bus_req_i.data} > max_lim |=> eom_r)
    else $error("start address beyond drum not flagged");

  COV_SECTOR: cover property (@(posedge clock_i) disable iff (!reset_n_i) sect_end);
  COV_WRITE_PAR: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    wr_mode_r && par_tick);
  COV_FIFO_FULL: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    state_r == dsc_pkg::DSC_DATA && !fifo_in_ready);
  COV_SENSE: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    hit && bus_req_i.sense && examine);
endmodule

// ---- bench/dsc_chan_model.sv ----
// Selector channel partner: byte source in write mode, byte sink in read mode
`timescale 1ns/100ps
module dsc_chan_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Bench control
  input  wire logic       en_i,
  input  wire logic       rd_en_i,
  // Bytes toward the controller
  input  wire logic       wr_ready_i,
  output logic            wr_valid_o,
  output logic      [7:0] wr_data_o,
  // Bytes from the controller
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_data_i,
  output logic            rd_ready_o,
  output logic      [7:0] rd_count_o,
  output logic            rd_bad_o
);
  logic [7:0] cnt_r;

  // Byte held until taken; count restarts once the channel is released
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_valid_o <= 1'b0;
      cnt_r      <= 8'h00;
    end
    else if (wr_valid_o && wr_ready_i)
    begin
      wr_valid_o <= en_i;
      cnt_r      <= cnt_r + 8'h01;
    end
    else if (!wr_valid_o)
    begin
      wr_valid_o <= en_i;
      cnt_r      <= en_i ? cnt_r : 8'h00;
    end
  end

  // Released data shows the inverse, never a stale copy
  assign wr_data_o  = wr_valid_o ? cnt_r : ~cnt_r;
  // Sink only in read mode; write-mode FIFO words are not channel bytes
  assign rd_ready_o = rd_en_i;

  // Read bytes must follow the drum pattern in order
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_count_o <= 8'h00;
      rd_bad_o   <= 1'b0;
    end
    else if (rd_valid_i && rd_ready_o)
    begin
      rd_bad_o   <= rd_bad_o | (rd_data_i != rd_count_o);
      rd_count_o <= rd_count_o + 8'h01;
    end
  end
endmodule

// ---- bench/tb_drum_storage_controller.sv ----
// Self-checking bench of the drum storage controller
`timescale 1ns/100ps
module tb_drum_storage_controller;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  dsc_pkg::dsc_bus_req_t req = '0;
  logic                  idle = 1'b1;
  logic                  tick = 1'b0;
  logic            [7:0] rdat = 8'h00;
  logic                  spd = 1'b1;
  logic                  hds = 1'b1;
  logic            [2:0] cap = 3'h4;
  logic           [31:0] prot = 32'h0;
  logic                  en = 1'b0;
  logic                  rden = 1'b0;
  logic            [7:0] rn = 8'h00;
  logic                  resp, wrdy, rvld, busy, term, dwe, eng, mwv, mrr, mbad;
  logic            [7:0] bdat, rdata, dwd, mwd, mcnt;
  logic           [15:0] sec;
  int                    err_count = 0;
  int                    num_checks = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  dsc_ctrl dut_u (.clock_i(clk), .reset_n_i(rst_n), .bus_req_i(req), .chan_idle_i(idle),
    .bus_resp_o(resp), .bus_data_o(bdat), .chan_wr_valid_i(mwv), .chan_wr_data_i(mwd),
    .chan_wr_ready_o(wrdy), .chan_rd_valid_o(rvld), .chan_rd_data_o(rdata),
    .chan_rd_ready_i(mrr), .chan_busy_o(busy), .chan_term_o(term), .drum_tick_i(tick),
    .drum_rd_data_i(rdat), .drum_wr_data_o(dwd), .drum_wr_en_o(dwe), .drum_sector_o(sec),
    .drum_speed_ok_i(spd), .drum_heads_ok_i(hds), .drum_heads_engage_o(eng),
    .cap_sel_i(cap), .protect_i(prot));

  dsc_chan_model chan_u (.clock_i(clk), .reset_n_i(rst_n), .en_i(en), .rd_en_i(rden),
    .wr_ready_i(wrdy),
    .wr_valid_o(mwv), .wr_data_o(mwd), .rd_valid_i(rvld), .rd_data_i(rdata),
    .rd_ready_o(mrr), .rd_count_o(mcnt), .rd_bad_o(mbad));

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus request cycle; the answer is visible on return
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic [2:0] k);
    @(posedge clk);
    #1 req = {a, d, k};
    @(posedge clk);
    #1 req = '0;
  endtask

  // Busy is masked: it follows idle and FIFO state as well as the stop flags
  task automatic sense(input logic [7:0] exp);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h00, 3'b100);
    chk("resp", 16'h1, {15'h0, resp});
    chk("status", {8'h00, exp}, {8'h00, bdat & 8'hF7});
  endtask

  // One drum byte slot
  task automatic tk(input logic [7:0] d);
    @(posedge clk);
    #1 tick = 1'b1;
    rdat = d;
    @(posedge clk);
    #1 tick = 1'b0;
    rdat = ~d;
  endtask

  // Ticks until the controller ends the transfer
  task automatic run_to_term(input int n);
    for (int k = 0; k < n && term !== 1'b1; k++)
      tk(8'h00);
    chk("term", 16'h1, {15'h0, term});
  endtask

  task automatic t_bus;
    sense(8'h00);
    bus(8'h87, 8'h00, 3'b100);
    chk("foreign resp", 16'h0, {15'h0, resp});
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h00, 3'b010);
    sense(8'h84);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h02, 3'b010);
    sense(8'h00);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h03, 3'b010);
    sense(8'h84);
    spd = 1'b0;
    repeat (3) @(posedge clk);
    chk("engage", 16'h0, {15'h0, eng});
    sense(8'h85);
    spd = 1'b1;
    hds = 1'b0;
    repeat (3) @(posedge clk);
    sense(8'h85);
    hds = 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_write;
    logic [7:0] par;
    logic [7:0] v;
    par = 8'h00;
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h01, 3'b010);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h00, 3'b001);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h05, 3'b001);
    chk("sector", 16'h0005, sec);
    en = 1'b1;
    idle = 1'b0;
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h00, 3'b100);
    chk("busy resp", 16'h0, {15'h0, resp});
    chk("busy", 16'h0, {15'h0, busy});
    repeat (10) @(posedge clk);
    for (int k = 0; k < 132; k++)
    begin
      v = 8'(k - k / 33);
      tk(8'h00);
      chk("wr_en", 16'h1, {15'h0, dwe});
      if (k % 33 == 32)
      begin
        chk("parity", {8'h00, par}, {8'h00, dwd});
        par = 8'h00;
      end
      else
      begin
        chk("wr_data", {8'h00, v}, {8'h00, dwd});
        par = par ^ v;
      end
    end
    chk("sector", 16'h0006, sec);
    en = 1'b0;
    run_to_term(12);
    idle = 1'b1;
    sense(8'h84);
  endtask

  task automatic t_read;
    logic [7:0] d;
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h02, 3'b010);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h00, 3'b001);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h07, 3'b001);
    rden = 1'b1;
    idle = 1'b0;
    for (int k = 0; k < 66; k++)
    begin
      if (k == 33)
      begin
        chk("rd count", 16'h0020, {8'h00, mcnt});
        chk("rd bad", 16'h0, {15'h0, mbad});
      end
      if (k == 32)
        d = 8'h00;
      else if (k == 65)
        d = 8'h5A;
      else
      begin
        d = rn;
        rn = rn + 8'h01;
      end
      tk(d);
    end
    run_to_term(4);
    rden = 1'b0;
    idle = 1'b1;
    sense(8'h44);
  endtask

  task automatic t_limits;
    cap = 3'h0;
    // Start on the top sector; one full sector must run past the end
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h02, 3'b010);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h03, 3'b001);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'hFF, 3'b001);
    rden = 1'b1;
    idle = 1'b0;
    run_to_term(140);
    rden = 1'b0;
    idle = 1'b1;
    sense(8'h02);
    // Start address beyond the drum flags at load time
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h02, 3'b010);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h04, 3'b001);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h00, 3'b001);
    sense(8'h02);
    cap = 3'h4;
    prot = 32'h1;
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h01, 3'b010);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h00, 3'b001);
    bus(dsc_pkg::DEV_ADDR_DEF, 8'h00, 3'b001);
    en = 1'b1;
    idle = 1'b0;
    repeat (4) @(posedge clk);
    run_to_term(40);
    en = 1'b0;
    idle = 1'b1;
    sense(8'h14);
    prot = 32'h0;
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);  // Unavailable shows until heads engage
    t_bus();
    t_write();
    t_read();
    t_limits();
    end_of_test();
  end
endmodule
